// >>> include/spcfg_pkg.sv
package spcfg_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] CFG_A_ADDR = 16'h0000;
    localparam logic [15:0] CFG_B_ADDR = 16'h0001;
    localparam int A_FULL_RST_BIT = 7;
    localparam int A_LSB_FIRST_BIT = 6;
    localparam int A_ASCEND_BIT = 5;
    localparam int A_ASCEND_MIR_BIT = 2;
    localparam int A_LSB_MIR_BIT = 1;
    localparam int A_FULL_MIR_BIT = 0;
    localparam int B_RD_SHADOW_BIT = 5;
    localparam int B_CORE_RST_BIT = 2;
    localparam logic [7:0] CFG_A_RESET = 8'h00;
    localparam logic [7:0] CFG_B_RESET = 8'h00;
    // Only the stored bits; reset triggers read back as live status instead
    localparam logic [7:0] CFG_A_STORE_MASK = 8'h66;
    localparam logic [7:0] CFG_B_STORE_MASK = 8'h20;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RST_PULSE_NS = 40;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    typedef enum logic [1:0] {
        SPCFG_IDLE = 2'b00,
        SPCFG_FULL = 2'b01,
        SPCFG_CORE = 2'b10
    } spcfg_rst_e;
endpackage

// >>> include/spcfg_rst_if.sv
interface spcfg_rst_if;
    logic full_req;
    logic core_req;
    logic full_act;
    logic core_act;
    logic full_done;
    modport ctrl (output full_req, output core_req, input full_act, input core_act,
                  input full_done);
    modport gen (input full_req, input core_req, output full_act, output core_act,
                 output full_done);
endinterface

// >>> rtl/spcfg_regs.sv
// What this block does
// - Config A bit 6 set shifts LSB first; reset value 0 means MSB first.
// - Bit order and address step are forced off while the port runs I2C.
// - Config A bit 5 set steps the address upward per multibyte SPI byte.
// - Config A bit 5 clear, its reset value, steps the address downward.
// - Bits 2 to 0 mirror 7 to 5; each control is the OR of the pair.
// - Mirror pairs are reversed: 2 with 5, 1 with 6, 0 with 7; bits 4 and 3 are reserved and read 0.
// - Config B bit 5 set makes buffered reads return the shadow copy.
// - Config B bit 5 clear, its reset value, returns the active values.
// - Writing 1 to config B bit 2 resets logic only; writing 0 does nothing.
module spcfg_regs
    import spcfg_pkg::*;
#(
    parameter int PULSE_CYC = RST_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic i2c_mode,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] active_rdata,
    input wire logic [7:0] shadow_rdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic lsb_first,
    output logic addr_ascend,
    output logic read_shadow,
    output logic full_reset,
    output logic logic_reset
);
    spcfg_rst_if rif ();

    spcfg_rst_gen #(
        .PULSE_CYC(PULSE_CYC)
    ) u_rst_gen (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .rif(rif)
    );

    logic [7:0] cfg_a_q, cfg_a_d;
    logic [7:0] cfg_b_q, cfg_b_d;
    logic lsb_q, asc_q, shadow_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    wire sel_a = (reg_addr == CFG_A_ADDR);
    wire sel_b = (reg_addr == CFG_B_ADDR);
    wire wr_a = reg_wr && sel_a;
    wire wr_b = reg_wr && sel_b;
    wire rst_busy = rif.full_act || rif.core_act;

    // Trigger bits are never stored, so a write during a reset cannot leave one stuck
    wire full_trig = wr_a && (reg_wdata[A_FULL_RST_BIT] || reg_wdata[A_FULL_MIR_BIT]);
    wire core_trig = wr_b && reg_wdata[B_CORE_RST_BIT];
    assign rif.full_req = full_trig && !rst_busy;
    assign rif.core_req = core_trig && !rst_busy;

    wire lsb_raw = cfg_a_q[A_LSB_FIRST_BIT] || cfg_a_q[A_LSB_MIR_BIT];
    wire asc_raw = cfg_a_q[A_ASCEND_BIT] || cfg_a_q[A_ASCEND_MIR_BIT];
    wire lsb_d = lsb_raw && !i2c_mode;
    wire asc_d = asc_raw && !i2c_mode;

    wire [7:0] a_rd = cfg_a_q | {rif.full_act, 6'h00, rif.full_act};
    wire [7:0] b_rd = cfg_b_q | {5'h00, rif.core_act, 2'h0};
    wire [7:0] buf_rd = cfg_b_q[B_RD_SHADOW_BIT] ? shadow_rdata : active_rdata;
    wire [7:0] rdata_d = sel_a ? a_rd : (sel_b ? b_rd : buf_rd);

    // A write landing with the end of a full reset wins over the map clear
    always_comb begin
        cfg_a_d = cfg_a_q;
        cfg_b_d = cfg_b_q;
        if (rif.full_done) begin
            cfg_a_d = CFG_A_RESET;
            cfg_b_d = CFG_B_RESET;
        end
        if (wr_a) begin
            cfg_a_d = reg_wdata & CFG_A_STORE_MASK;
        end
        if (wr_b) begin
            cfg_b_d = reg_wdata & CFG_B_STORE_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_a_q <= CFG_A_RESET;
            cfg_b_q <= CFG_B_RESET;
            lsb_q <= 1'b0;
            asc_q <= 1'b0;
            shadow_q <= 1'b0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
            lsb_q <= lsb_d;
            asc_q <= asc_d;
            shadow_q <= cfg_b_q[B_RD_SHADOW_BIT];
            rdata_q <= reg_rd ? rdata_d : rdata_q;
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign lsb_first = lsb_q;
    assign addr_ascend = asc_q;
    assign read_shadow = shadow_q;
    assign full_reset = rif.full_act;
    assign logic_reset = rif.core_act;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    i2c_order_off_a: assert property (i2c_mode |=> !lsb_first && !addr_ascend)
        else $error("bit order or address step active in I2C mode");
    lsb_mirror_a: assert property (wr_a && reg_wdata == 8'h02 && !i2c_mode ##1 !i2c_mode
        |=> lsb_first && !addr_ascend)
        else $error("mirror bit 1 did not select LSB first");
    asc_mirror_a: assert property (wr_a && reg_wdata == 8'h04 && !i2c_mode ##1 !i2c_mode
        |=> addr_ascend && !lsb_first)
        else $error("mirror bit 2 did not select ascending address");
    desc_default_a: assert property (wr_a && reg_wdata == 8'h00 ##1 !wr_a |=> !addr_ascend)
        else $error("address step not descending after clearing");
    reserved_zero_a: assert property (reg_rd && sel_a |=> reg_rdata[4:3] == 2'b00)
        else $error("reserved bits of config A read nonzero");
    shadow_read_a: assert property (reg_rd && !sel_a && !sel_b && cfg_b_q[B_RD_SHADOW_BIT]
        |=> reg_rdata == $past(shadow_rdata))
        else $error("shadow read returned wrong data");
    active_read_a: assert property (reg_rd && !sel_a && !sel_b && !cfg_b_q[B_RD_SHADOW_BIT]
        |=> reg_rdata == $past(active_rdata))
        else $error("active read returned wrong data");
    core_pulse_a: assert property (rif.core_req |=> logic_reset [*8] ##1 !logic_reset)
        else $error("logic reset pulse has wrong length");
    core_noop_a: assert property (wr_b && !reg_wdata[B_CORE_RST_BIT] && !rst_busy
        |=> !logic_reset)
        else $error("writing zero started a logic reset");
    full_clear_a: assert property (rif.full_done && !wr_a ##1 !wr_a
        |=> !lsb_first && !addr_ascend)
        else $error("full reset left config A set");
    full_self_clear_a: assert property (rif.full_req |=> full_reset [*8] ##1 !full_reset)
        else $error("full reset bit did not self clear");

    full_reset_c: cover property (rif.full_req ##[1:20] rif.full_done);
    core_reset_c: cover property (rif.core_req ##[1:20] !logic_reset);
    shadow_read_c: cover property (reg_rd && !sel_a && !sel_b && cfg_b_q[B_RD_SHADOW_BIT]);
    lsb_set_c: cover property (!lsb_first ##1 lsb_first);
endmodule

// >>> rtl/spcfg_rst_gen.sv
module spcfg_rst_gen
    import spcfg_pkg::*;
#(
    parameter int PULSE_CYC = RST_PULSE_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    spcfg_rst_if.gen rif
);
    localparam int CW = $clog2(PULSE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(PULSE_CYC - 1);

    spcfg_rst_e state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic full_act_q, core_act_q, full_done_q;

    wire cnt_end = (cnt_q == CNT_LAST);
    wire busy = (state_q != SPCFG_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d = busy ? cnt_q + CW'(1) : '0;
        unique case (state_q)
            SPCFG_IDLE: begin
                // A full reset outranks a logic-only reset asked in the same cycle
                if (rif.full_req) begin
                    state_d = SPCFG_FULL;
                end else if (rif.core_req) begin
                    state_d = SPCFG_CORE;
                end
            end
            SPCFG_FULL, SPCFG_CORE: begin
                if (cnt_end) begin
                    state_d = SPCFG_IDLE;
                end
            end
            default: state_d = SPCFG_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= SPCFG_IDLE;
            cnt_q <= '0;
            full_act_q <= 1'b0;
            core_act_q <= 1'b0;
            full_done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            full_act_q <= (state_d == SPCFG_FULL);
            core_act_q <= (state_d == SPCFG_CORE);
            full_done_q <= (state_q == SPCFG_FULL) && cnt_end;
        end
    end

    assign rif.full_act = full_act_q;
    assign rif.core_act = core_act_q;
    assign rif.full_done = full_done_q;
endmodule

// >>> sim/spcfg_host.sv
module spcfg_host
    import spcfg_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic [7:0] active_rdata,
    output logic [7:0] shadow_rdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    // Copies differ per address so a swapped read mux cannot hide
    assign active_rdata = reg_addr[7:0] ^ 8'h5A;
    assign shadow_rdata = reg_addr[7:0] ^ 8'hA5;
    initial begin
        reg_addr = '0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
        // Released data no longer shows the last byte
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule

// >>> sim/tb_top.sv
module tb_top
    import spcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] wd; logic i2c; logic [7:0] rb; logic lsb; logic asc;} spcfg_row_s;
    spcfg_row_s rows [7] = '{'{8'h40, 1'h0, 8'h40, 1'h1, 1'h0}, '{8'h02, 1'h0, 8'h02, 1'h1, 1'h0},
        '{8'h20, 1'h0, 8'h20, 1'h0, 1'h1}, '{8'h04, 1'h0, 8'h04, 1'h0, 1'h1},
        '{8'h66, 1'h1, 8'h66, 1'h0, 1'h0}, '{8'h66, 1'h0, 8'h66, 1'h1, 1'h1},
        '{8'h18, 1'h0, 8'h00, 1'h0, 1'h0}};
    logic mclk, sys_rst, i2c_mode, reg_wr, reg_rd, reg_rvalid, v;
    logic lsb_first, addr_ascend, read_shadow, full_reset, logic_reset;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, active_rdata, shadow_rdata, reg_rdata, d;
    int error_cnt = 0;
    int n_checks = 0;
    int n;
    spcfg_regs uut (.mclk(mclk), .sys_rst(sys_rst), .i2c_mode(i2c_mode), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .active_rdata(active_rdata),
        .shadow_rdata(shadow_rdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .lsb_first(lsb_first), .addr_ascend(addr_ascend), .read_shadow(read_shadow),
        .full_reset(full_reset), .logic_reset(logic_reset));
    spcfg_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .active_rdata(active_rdata), .shadow_rdata(shadow_rdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Counts high cycles of one reset output, bounded in case it sticks
    task automatic hi_len(input logic full, output int c);
        c = 0;
        #1;
        while ((full ? full_reset : logic_reset) === 1'h1 && c < 20) begin
            c++;
            @(posedge mclk);
            #1;
        end
    endtask
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #25000;
        error_cnt++;
        close_out();
    end
    initial begin
        sys_rst = 1'h1;
        i2c_mode = 1'h0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'h0;
        #1;
        chk({lsb_first, addr_ascend, read_shadow, full_reset, logic_reset}, 8'h00);
        host.rd(CFG_A_ADDR, d, v);
        chk(d, CFG_A_RESET);
        host.rd(CFG_B_ADDR, d, v);
        chk(d, CFG_B_RESET);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge mclk);
            i2c_mode <= rows[i].i2c;
            host.wr(CFG_A_ADDR, rows[i].wd);
            host.rd(CFG_A_ADDR, d, v);
            chk(d, rows[i].rb);
            chk({lsb_first, addr_ascend}, {rows[i].lsb, rows[i].asc});
        end
        $display("test config a done");
        host.wr(CFG_B_ADDR, 8'h20);
        host.rd(16'h0123, d, v);
        chk(d, 8'h23 ^ 8'hA5);
        chk(8'(v), 8'h01);
        chk(read_shadow, 8'h01);
        host.wr(CFG_B_ADDR, 8'h00);
        host.rd(16'h0123, d, v);
        chk(d, 8'h23 ^ 8'h5A);
        chk(8'(v), 8'h01);
        $display("test read select done");
        host.wr(CFG_A_ADDR, 8'h22);
        host.wr(CFG_B_ADDR, 8'h20);
        host.wr(CFG_B_ADDR, 8'h00);
        #1;
        chk(logic_reset, 8'h00);
        host.wr(CFG_B_ADDR, 8'h24);
        hi_len(1'h0, n);
        chk(8'(n), 8'h08);
        host.rd(CFG_A_ADDR, d, v);
        chk(d, 8'h22);
        $display("test logic reset done");
        host.wr(CFG_A_ADDR, 8'h01);
        hi_len(1'h1, n);
        chk(8'(n), 8'h08);
        repeat (2) @(posedge mclk);
        host.rd(CFG_A_ADDR, d, v);
        chk(d, 8'h00);
        host.rd(CFG_B_ADDR, d, v);
        chk(d, 8'h00);
        chk({lsb_first, addr_ascend, read_shadow}, 8'h00);
        $display("test full reset done");
        close_out();
    end
endmodule
